/* File: hw/pms_pkg.sv */
// shared constants for the management serial slave
// assumes a single 50 MHz clock domain; MDC arrives as a plain pin
package pms_pkg;

  // register bus layout
  localparam int          PMS_AXI_AW      = 8;
  localparam logic [7:0]  PMS_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  PMS_EVENT_OFS   = 8'h04;
  localparam logic [7:0]  PMS_STATUS_OFS  = 8'h08;
  localparam logic [1:0]  PMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PMS_RESP_SLVERR = 2'h2;

  // control register fields
  localparam int          PMS_CTRL_W      = 5;
  localparam int          PMS_BCAST_BIT   = 0;
  localparam int          PMS_MDIO_PP_BIT = 1;
  localparam int          PMS_INT_PP_BIT  = 2;
  localparam int          PMS_INT_INV_BIT = 3;
  localparam int          PMS_PRE_SKIP_BIT = 4;
  localparam logic [4:0]  PMS_CTRL_RESET  = 5'h00;

  // status register fields
  localparam int          PMS_ST_STRAP_LSB = 0;
  localparam int          PMS_ST_ISR_LSB   = 8;
  localparam int          PMS_ST_IRQ_BIT   = 24;
  localparam int          PMS_ST_CNT_LSB   = 25;
  localparam int          PMS_CNT_W        = 7;

  // management frame
  localparam int          PMS_ADDR_W      = 5;
  localparam int          PMS_DATA_W      = 16;
  localparam int          PMS_REG_COUNT   = 32;
  localparam logic [5:0]  PMS_PREAMBLE_ONES = 6'h20;
  localparam logic [1:0]  PMS_OP_READ     = 2'h2;
  localparam logic [1:0]  PMS_OP_WRITE    = 2'h1;
  localparam logic [4:0]  PMS_OP_LAST     = 5'h01;
  localparam logic [4:0]  PMS_ADDR_LAST   = 5'h04;
  localparam logic [4:0]  PMS_TA_LAST     = 5'h01;
  localparam logic [4:0]  PMS_DATA_LAST   = 5'h0f;
  localparam logic [4:0]  PMS_SKIP_START  = 5'h1d;
  localparam logic [4:0]  PMS_SKIP_OP     = 5'h1b;
  localparam logic [4:0]  PMS_BCAST_ADDR  = 5'h00;

  // interrupt registers inside the 32-entry space
  localparam logic [4:0]  PMS_IER_IDX     = 5'h1b;
  localparam logic [4:0]  PMS_ISR_IDX     = 5'h1c;
  localparam int          PMS_EV_W        = 12;
  localparam int          PMS_SUM_W       = 4;
  localparam logic [15:0] PMS_IER_RESET   = 16'h0000;

  typedef enum logic [2:0] {
    PMS_ST_IDLE  = 3'h0,
    PMS_ST_START = 3'h1,
    PMS_ST_OP    = 3'h3,
    PMS_ST_PHY   = 3'h2,
    PMS_ST_REG   = 3'h6,
    PMS_ST_TA    = 3'h7,
    PMS_ST_DATA  = 3'h5,
    PMS_ST_SKIP  = 3'h4
  } pms_state_type;

endpackage : pms_pkg

/* File: hw/pms_regfile.sv */
// 32 x 16 management register store with registered read data
// assumes one write or one read request per cycle from the frame decoder
module pms_regfile
  import pms_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  we,
  input  wire logic [PMS_ADDR_W-1:0] waddr,
  input  wire logic [PMS_DATA_W-1:0] wdata,
  input  wire logic [PMS_ADDR_W-1:0] raddr,
  output logic      [PMS_DATA_W-1:0] rdata_q
);

  logic [PMS_DATA_W-1:0] mem [PMS_REG_COUNT];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : pms_regfile

/* File: hw/pms_mgmt_slave.sv */
// management serial slave: frame decoder, 32-entry space, interrupt pin
// assumes MDC/MDIO and straps are asynchronous pins; AXI4-Lite on clk
//
// Notes on behaviour
// - frame is 32 ones, 01, read/write opcode
// - turnaround then sixteen data bits, device drives 0
// - respond when address equals strap value
// - five-bit register address picks one of 32
// - broadcast enable also accepts address zero
// - data pin open-drain or push-pull by control
// - start code other than 01 is ignored
// - bad start code discards entire frame
// - interrupt asserts only for enabled conditions
// - status bits set regardless of enables
// - reading status register clears most bits
// - summary status bits are read-only, uncleared
// - interrupt driver type selectable, open-drain default
// - interrupt polarity selectable, active low default
// - open-drain interrupt forced active low
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module pms_mgmt_slave
  import pms_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [PMS_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [PMS_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  mdc,
  input  wire logic                  mdio_in,
  output logic                       mdio_out,
  output logic                       mdio_oe,
  input  wire logic [PMS_ADDR_W-1:0] station_address_strap,
  input  wire logic [PMS_EV_W-1:0]   event_pulse,
  input  wire logic [PMS_SUM_W-1:0]  summary_src,
  output logic                       irq_out,
  output logic                       irq_oe
);

  // pin synchronisers
  logic                  mdc_s1_q, mdc_s2_q, mdc_s3_q;
  logic                  mdio_s1_q, mdio_s2_q;
  logic [PMS_ADDR_W-1:0] strap_s1_q, strap_s2_q, strap_q;

  always_ff @(posedge clk)
  begin
    mdc_s1_q   <= mdc;
    mdc_s2_q   <= mdc_s1_q;
    mdc_s3_q   <= mdc_s2_q;
    mdio_s1_q  <= mdio_in;
    mdio_s2_q  <= mdio_s1_q;
    strap_s1_q <= station_address_strap;
    strap_s2_q <= strap_s1_q;
  end

  // strap caught while reset is held, kept afterwards
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_q <= strap_s2_q;
    end
  end

  wire logic mdc_rise = mdc_s2_q & ~mdc_s3_q;
  wire logic bit_in   = mdio_s2_q;

  // control register
  logic [PMS_CTRL_W-1:0] ctrl_q;
  wire logic bcast_en  = ctrl_q[PMS_BCAST_BIT];
  wire logic mdio_pp   = ctrl_q[PMS_MDIO_PP_BIT];
  wire logic int_pp    = ctrl_q[PMS_INT_PP_BIT];
  wire logic pre_skip  = ctrl_q[PMS_PRE_SKIP_BIT];
  wire logic inv_eff   = ctrl_q[PMS_INT_INV_BIT] & int_pp;

  // frame decoder
  pms_state_type         state_q, state_d;
  logic [4:0]            cnt_q, cnt_d;
  logic [5:0]            ones_q, ones_d;
  logic [PMS_DATA_W-1:0] shift_q, tx_q;
  logic [PMS_ADDR_W-1:0] phy_q, reg_q;
  logic                  is_read_q, match_q, drive_q, out_bit_q;
  logic [PMS_CNT_W-1:0]  served_q;

  wire logic [PMS_DATA_W-1:0] shift_nx = {shift_q[PMS_DATA_W-2:0], bit_in};
  wire logic [1:0] op_code  = {shift_q[0], bit_in};
  wire logic       op_ok    = (op_code == PMS_OP_READ) || (op_code == PMS_OP_WRITE);
  wire logic       pre_ok   = (ones_q == PMS_PREAMBLE_ONES) || (pre_skip && ones_q != 6'h00);
  wire logic       last_bit = (cnt_q == 5'h00);
  wire logic [PMS_ADDR_W-1:0] reg_nx = shift_nx[PMS_ADDR_W-1:0];
  wire logic addr_hit = (phy_q == strap_q) || (bcast_en && phy_q == PMS_BCAST_ADDR);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ones_d  = ones_q;
    if (mdc_rise)
    begin
      cnt_d = cnt_q - 5'h01;
      unique case (state_q)
        PMS_ST_IDLE:
        begin
          if (bit_in)
          begin
            ones_d = (ones_q == PMS_PREAMBLE_ONES) ? ones_q : ones_q + 6'h01;
          end
          else
          begin
            ones_d = 6'h00;
            if (pre_ok)
            begin
              state_d = PMS_ST_START;
            end
          end
        end
        PMS_ST_START:
        begin
          state_d = bit_in ? PMS_ST_OP : PMS_ST_SKIP;
          cnt_d   = bit_in ? PMS_OP_LAST : PMS_SKIP_START;
        end
        PMS_ST_OP:
        begin
          if (last_bit)
          begin
            state_d = op_ok ? PMS_ST_PHY : PMS_ST_SKIP;
            cnt_d   = op_ok ? PMS_ADDR_LAST : PMS_SKIP_OP;
          end
        end
        PMS_ST_PHY:
        begin
          if (last_bit)
          begin
            state_d = PMS_ST_REG;
            cnt_d   = PMS_ADDR_LAST;
          end
        end
        PMS_ST_REG:
        begin
          if (last_bit)
          begin
            state_d = PMS_ST_TA;
            cnt_d   = PMS_TA_LAST;
          end
        end
        PMS_ST_TA:
        begin
          if (last_bit)
          begin
            state_d = PMS_ST_DATA;
            cnt_d   = PMS_DATA_LAST;
          end
        end
        PMS_ST_DATA, PMS_ST_SKIP:
        begin
          if (last_bit)
          begin
            state_d = PMS_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= PMS_ST_IDLE;
      cnt_q   <= 5'h00;
      ones_q  <= 6'h00;
      shift_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ones_q  <= ones_d;
      if (mdc_rise)
      begin
        shift_q <= shift_nx;
      end
    end
  end

  // field capture and decode strobes
  wire logic rise_op   = mdc_rise && state_q == PMS_ST_OP && last_bit;
  wire logic rise_phy  = mdc_rise && state_q == PMS_ST_PHY && last_bit;
  wire logic rise_reg  = mdc_rise && state_q == PMS_ST_REG && last_bit;
  wire logic rise_ta1  = mdc_rise && state_q == PMS_ST_TA && !last_bit;
  wire logic rise_end  = mdc_rise && state_q == PMS_ST_DATA && last_bit;
  wire logic rd_serve  = rise_ta1 && is_read_q && match_q;
  wire logic shift_out = mdc_rise && drive_q && !(state_q == PMS_ST_DATA && last_bit);
  wire logic wr_apply  = rise_end && !is_read_q && match_q;
  wire logic isr_clr   = rd_serve && reg_q == PMS_ISR_IDX;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      is_read_q <= 1'b0;
      phy_q     <= '0;
      reg_q     <= '0;
      match_q   <= 1'b0;
    end
    else
    begin
      if (rise_op)
      begin
        is_read_q <= (op_code == PMS_OP_READ);
      end
      if (rise_phy)
      begin
        phy_q <= shift_nx[PMS_ADDR_W-1:0];
      end
      if (rise_reg)
      begin
        reg_q   <= reg_nx;
        match_q <= addr_hit;
      end
    end
  end

  // register store and interrupt registers
  logic [PMS_DATA_W-1:0] mem_rdata;
  logic [PMS_DATA_W-1:0] ier_q;
  logic [PMS_EV_W-1:0]   isr_q;
  logic [PMS_EV_W-1:0]   set_vec;
  wire logic [PMS_DATA_W-1:0] isr_view = {summary_src, isr_q};
  wire logic mem_we = wr_apply && reg_q != PMS_IER_IDX && reg_q != PMS_ISR_IDX;
  wire logic [PMS_DATA_W-1:0] rd_mux = (reg_q == PMS_IER_IDX) ? ier_q :
                                       (reg_q == PMS_ISR_IDX) ? isr_view : mem_rdata;

  pms_regfile u_regfile (
    .clk     (clk),
    .reset   (reset),
    .we      (mem_we),
    .waddr   (reg_q),
    .wdata   (shift_nx),
    .raddr   (reg_q),
    .rdata_q (mem_rdata)
  );

  // serial output: zero in second turnaround bit, then data msb first
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      drive_q   <= 1'b0;
      out_bit_q <= 1'b1;
      tx_q      <= '0;
      ier_q     <= PMS_IER_RESET;
      served_q  <= '0;
    end
    else
    begin
      if (rd_serve)
      begin
        drive_q   <= 1'b1;
        out_bit_q <= 1'b0;
        tx_q      <= rd_mux;
      end
      else if (shift_out)
      begin
        out_bit_q <= tx_q[PMS_DATA_W-1];
        tx_q      <= {tx_q[PMS_DATA_W-2:0], 1'b0};
      end
      else if (rise_end)
      begin
        drive_q   <= 1'b0;
        out_bit_q <= 1'b1;
      end
      if (wr_apply && reg_q == PMS_IER_IDX)
      begin
        ier_q <= shift_nx;
      end
      if (rise_end && match_q)
      begin
        served_q <= served_q + 7'h01;
      end
    end
  end

  // pin drive, open-drain unless push-pull selected
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end
    else
    begin
      mdio_out <= mdio_pp & out_bit_q;
      mdio_oe  <= drive_q & (mdio_pp | ~out_bit_q);
    end
  end

  // sticky status bits, set wins over clear-on-read
  genvar gi;
  generate
    for (gi = 0; gi < PMS_EV_W; gi++)
    begin : g_sticky
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          isr_q[gi] <= 1'b0;
        end
        else if (set_vec[gi])
        begin
          isr_q[gi] <= 1'b1;
        end
        else if (isr_clr)
        begin
          isr_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  wire logic irq_act = |(isr_view & ier_q);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end
    else
    begin
      irq_out <= int_pp & (inv_eff ? irq_act : ~irq_act);
      irq_oe  <= int_pp | irq_act;
    end
  end

  // AXI4-Lite slave
  logic                  aw_held_q, w_held_q;
  logic [PMS_AXI_AW-1:0] awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire logic wr_go    = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire logic wr_ctrl  = awaddr_q[7:2] == PMS_CTRL_OFS[7:2];
  wire logic wr_event = awaddr_q[7:2] == PMS_EVENT_OFS[7:2];
  wire logic [PMS_EV_W-1:0] ev_mask = {{4{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign set_vec = event_pulse |
                   ({PMS_EV_W{wr_go & wr_event}} & wdata_q[PMS_EV_W-1:0] & ev_mask);

  wire logic rd_ctrl   = s_axi_araddr[7:2] == PMS_CTRL_OFS[7:2];
  wire logic rd_status = s_axi_araddr[7:2] == PMS_STATUS_OFS[7:2];
  wire logic [31:0] status_word = {served_q, irq_act, isr_view, 3'h0, strap_q};
  wire logic [31:0] rd_word = rd_ctrl   ? {27'h000_0000, ctrl_q} :
                              rd_status ? status_word : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PMS_RESP_OKAY;
      ctrl_q       <= PMS_CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_held_q <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ctrl || wr_event) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go && wr_ctrl && wstrb_q[0])
      begin
        ctrl_q <= wdata_q[PMS_CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= PMS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_ctrl || rd_status) ? PMS_RESP_OKAY : PMS_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ta_zero_a: assert property ($rose(drive_q) |-> !out_bit_q)
    else $error("turnaround bit not driven low");
  bad_start_a: assert property (mdc_rise && state_q == PMS_ST_START && !bit_in
    |=> state_q == PMS_ST_SKIP)
    else $error("bad start code not discarded");
  skip_quiet_a: assert property (state_q == PMS_ST_SKIP |-> !drive_q && !mem_we)
    else $error("discarded frame acted on");
  addr_match_a: assert property (mem_we |-> phy_q == strap_q
    || (bcast_en && phy_q == PMS_BCAST_ADDR))
    else $error("write to foreign address");
  od_drive_a: assert property (drive_q && out_bit_q && !mdio_pp |=> !mdio_oe)
    else $error("open-drain pin drove high");
  bit_timing_a: assert property ($changed(out_bit_q) |-> $past(mdc_rise))
    else $error("output changed off clock edge");
  sticky_set_a: assert property (set_vec != '0 |=> (isr_q & $past(set_vec)) == $past(set_vec))
    else $error("status event lost");
  clr_read_a: assert property (isr_clr && set_vec == '0 |=> isr_q == '0)
    else $error("status not cleared on read");
  irq_on_a: assert property (irq_act |=> irq_oe && irq_out == $past(inv_eff))
    else $error("interrupt not asserted");
  irq_off_a: assert property (!irq_act |=> !irq_oe || irq_out != $past(inv_eff))
    else $error("interrupt asserted without enable");
  od_low_a: assert property (!$past(int_pp) |-> !irq_out)
    else $error("open-drain interrupt driven high");

  read_cov: cover property ($fell(drive_q));
  write_cov: cover property (mem_we);
  skip_cov: cover property (state_q == PMS_ST_SKIP);
  irq_cov: cover property (irq_act && ier_q != '0);

endmodule : pms_mgmt_slave

/* File: dv/pms_mdio_station.sv */
// station-management controller model: clocks frames over mdc/mdio
// assumes mdio_line is the resolved wire with its pull-up; mdc stands low between frames
module pms_mdio_station (
  output logic      mdc,
  output logic      mdio_en,
  output logic      mdio_val,
  input  wire logic mdio_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // single device on the bus, so 6.25 MHz is allowed in open-drain mode
  localparam int HALF = 80;

  initial
  begin
    mdc = 1'b0;
    mdio_en = 1'b0;
    mdio_val = 1'b1;
  end

  // change while mdc low, sample at the rising edge
  task automatic bit_io(input logic en, input logic v, output logic s);
    mdio_en <= en;
    mdio_val <= v;
    #HALF;
    mdc <= 1'b1;
    s = mdio_line;
    #HALF;
    mdc <= 1'b0;
  endtask : bit_io

  task automatic raw(input int n, input logic [63:0] v);
    logic s;
    for (int i = n - 1; i >= 0; i--) bit_io(1'b1, v[i], s);
    mdio_en <= 1'b0;
    #(8 * HALF);
  endtask : raw

  task automatic frame(input int pre, input logic [1:0] st, input logic [1:0] op,
                       input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ta);
    logic        s;
    logic [13:0] hdr;
    hdr = {st, op, phy, rg};
    ta = 1'b1;
    rd = 16'h0000;
    for (int i = 0; i < pre; i++) bit_io(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], s);
    if (op == 2'b10)
    begin
      // released turnaround, device answers
      bit_io(1'b0, 1'b1, s);
      bit_io(1'b0, 1'b1, ta);
      for (int i = 15; i >= 0; i--) bit_io(1'b0, 1'b1, rd[i]);
    end
    else
    begin
      bit_io(1'b1, 1'b1, s);
      bit_io(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_io(1'b1, wd[i], s);
    end
    mdio_en <= 1'b0;
    #(8 * HALF);
  endtask : frame
endmodule : pms_mdio_station

/* File: dv/pms_mgmt_slave_tb.sv */
// self-checking bench for the management serial slave
// assumes pms_pkg and the station model; AXI4-Lite master tasks on clk
module pms_mgmt_slave_tb
  import pms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] STRAP = 5'h13;
  logic        clk, reset, awvalid, wvalid, bready, arvalid, rready, mdc, st_en, st_val;
  logic        awready, wready, bvalid, arready, rvalid, mdio_out, mdio_oe, irq_out, irq_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, summary_src;
  logic [1:0]  bresp, rresp;
  logic [4:0]  strap;
  logic [11:0] event_pulse;
  wire logic   mdio_wire;
  int          num_errors, total_checks, cycles, hi_cnt;

  always #10 clk = ~clk;
  assign mdio_wire = (mdio_oe ? mdio_out : 1'b1) & (st_en ? st_val : 1'b1);

  pms_mgmt_slave u_dut (
    .clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mdc(mdc),
    .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .station_address_strap(strap), .event_pulse(event_pulse),
    .summary_src(summary_src), .irq_out(irq_out), .irq_oe(irq_oe));

  pms_mdio_station st (.mdc(mdc), .mdio_en(st_en), .mdio_val(st_val), .mdio_line(mdio_wire));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    cycles++;
    if (mdio_oe && mdio_out) hi_cnt++;
    if (cycles == 40000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h1;
    d = 32'h0000_0000;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
  endtask : axi_rd

  task automatic ctrl(input logic [31:0] v);
    logic [1:0] r;
    axi_wr(PMS_CTRL_OFS, v, r);
    chk("ctrl bresp", PMS_RESP_OKAY, r);
    repeat (3) @(posedge clk);
  endtask : ctrl

  task automatic mwr(input logic [4:0] p, input logic [4:0] g, input logic [15:0] d);
    logic [15:0] x;
    logic        t;
    st.frame(32, 2'b01, PMS_OP_WRITE, p, g, d, x, t);
  endtask : mwr

  task automatic mrd(input logic [4:0] p, input logic [4:0] g, output logic [15:0] d,
                     output logic t);
    st.frame(32, 2'b01, PMS_OP_READ, p, g, 16'h0000, d, t);
  endtask : mrd

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk("mdio_oe", 1'b0, mdio_oe);
    chk("irq_oe", 1'b0, irq_oe);
    axi_rd(PMS_STATUS_OFS, d, r);
    chk("status", {27'h000_0000, STRAP}, d);
    axi_rd(8'h0c, d, r);
    chk("rresp unmapped", PMS_RESP_SLVERR, r);
    axi_rd(PMS_EVENT_OFS, d, r);
    chk("rresp event", PMS_RESP_SLVERR, r);
    axi_wr(8'h0c, 32'hffff_ffff, r);
    chk("bresp unmapped", PMS_RESP_SLVERR, r);
    ctrl(32'h0000_001f);
    axi_rd(PMS_CTRL_OFS, d, r);
    chk("ctrl", 32'h0000_001f, d);
    ctrl(32'h0000_0000);
  endtask : t_reset

  task automatic t_rw;
    logic [4:0]  rg [4] = '{5'h00, 5'h01, 5'h1e, 5'h1f};
    logic [15:0] d;
    logic        t;
    logic [31:0] s;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++) mwr(STRAP, rg[i], 16'h8c31 ^ {11'h000, rg[i]});
    for (int i = 0; i < 4; i++)
    begin
      mrd(STRAP, rg[i], d, t);
      chk("ta", 1'b0, t);
      chk("rd", 16'h8c31 ^ {11'h000, rg[i]}, d);
    end
    mrd(5'h0c, 5'h01, d, t);
    chk("foreign rd", 16'hffff, d);
    axi_rd(PMS_STATUS_OFS, s, r);
    chk("frame count", 32'h0000_0008, {25'h000_0000, s[31:25]});
  endtask : t_rw

  task automatic t_bcast;
    logic [15:0] d;
    logic        t;
    mwr(STRAP, 5'h03, 16'h0f0f);
    mwr(5'h00, 5'h03, 16'h1111);
    mrd(STRAP, 5'h03, d, t);
    chk("bcast off", 16'h0f0f, d);
    ctrl(32'h0000_0001);
    mwr(5'h00, 5'h03, 16'h1234);
    mrd(STRAP, 5'h03, d, t);
    chk("bcast on", 16'h1234, d);
    ctrl(32'h0000_0000);
  endtask : t_bcast

  task automatic t_drive;
    logic [15:0] d;
    logic        t;
    int          h;
    mwr(STRAP, 5'h02, 16'ha5a5);
    h = hi_cnt;
    mrd(STRAP, 5'h02, d, t);
    chk("od rd", 16'ha5a5, d);
    chk("od high drive", 0, hi_cnt - h);
    ctrl(32'h0000_0002);
    h = hi_cnt;
    mrd(STRAP, 5'h02, d, t);
    chk("pp rd", 16'ha5a5, d);
    chk("pp high drive", 1'b1, hi_cnt > h);
    ctrl(32'h0000_0000);
  endtask : t_drive

  task automatic t_badstart;
    logic [15:0] d;
    logic        t;
    mwr(STRAP, 5'h06, 16'h5a5a);
    st.frame(32, 2'b00, PMS_OP_WRITE, STRAP, 5'h06, 16'hdead, d, t);
    mrd(STRAP, 5'h06, d, t);
    chk("bad start", 16'h5a5a, d);
    ctrl(32'h0000_0010);
    // tail of the bad frame looks like a write frame
    st.raw(64, {31'h0, 1'b1, 2'b00, 1'b1, 2'b01, PMS_OP_WRITE, STRAP, 5'h06, 2'b10, 13'h0bad});
    st.raw(3, 64'h0000_0000_0000_0007);
    mrd(STRAP, 5'h06, d, t);
    chk("bad start skip", 16'h5a5a, d);
    st.frame(1, 2'b01, PMS_OP_WRITE, STRAP, 5'h06, 16'h7777, d, t);
    mrd(STRAP, 5'h06, d, t);
    chk("skip frame", 16'h7777, d);
    ctrl(32'h0000_0000);
  endtask : t_badstart

  task automatic t_irq;
    logic [15:0] d;
    logic        t;
    logic [31:0] s;
    logic [1:0]  r;
    @(posedge clk);
    event_pulse <= 12'h008;
    @(posedge clk);
    event_pulse <= 12'h000;
    repeat (3) @(posedge clk);
    chk("irq masked", 1'b0, irq_oe);
    axi_rd(PMS_STATUS_OFS, s, r);
    chk("status event", 1'b1, s[PMS_ST_ISR_LSB + 3]);
    mwr(STRAP, PMS_IER_IDX, 16'h0008);
    repeat (3) @(posedge clk);
    chk("irq od", 2'b10, {irq_oe, irq_out});
    ctrl(32'h0000_0008);
    chk("irq od inv", 2'b10, {irq_oe, irq_out});
    ctrl(32'h0000_0004);
    chk("irq pp low", 2'b10, {irq_oe, irq_out});
    ctrl(32'h0000_000c);
    chk("irq pp high", 2'b11, {irq_oe, irq_out});
    summary_src <= 4'h2;
    mrd(STRAP, PMS_ISR_IDX, d, t);
    chk("isr", 16'h2008, d);
    chk("irq cleared", 2'b10, {irq_oe, irq_out});
    mrd(STRAP, PMS_ISR_IDX, d, t);
    chk("isr after", 16'h2000, d);
    mwr(STRAP, PMS_IER_IDX, 16'h2000);
    mrd(STRAP, PMS_ISR_IDX, d, t);
    chk("isr summary", 16'h2000, d);
    chk("irq summary", 2'b11, {irq_oe, irq_out});
    @(posedge clk);
    summary_src <= 4'h0;
    repeat (3) @(posedge clk);
    chk("irq gone", 2'b10, {irq_oe, irq_out});
    axi_wr(PMS_EVENT_OFS, 32'h0000_0801, r);
    chk("event bresp", PMS_RESP_OKAY, r);
    axi_rd(PMS_STATUS_OFS, s, r);
    chk("event set", 32'h0000_0801, {20'h0_0000, s[PMS_ST_ISR_LSB +: 12]});
    chk("irq event masked", 2'b10, {irq_oe, irq_out});
    ctrl(32'h0000_0000);
  endtask : t_irq

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    strap = STRAP;
    summary_src = 4'h0;
    event_pulse = 12'h000;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    hi_cnt = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_bcast();
    t_drive();
    t_badstart();
    t_irq();
    report_and_stop();
  end
endmodule : pms_mgmt_slave_tb
